// *** rtl/ook_modem_pkg.sv ***
package ook_modem_pkg;

  // Clock and oscillator chain
  localparam int CLK_HZ      = 50_000_000;
  localparam int OSC_HZ      = 2_000_000;
  localparam int OSC_DIV     = CLK_HZ / OSC_HZ;
  localparam int PRE_DIV     = 8;
  localparam int CAR_DIV     = 4;
  localparam int CAR_HALF    = CAR_DIV / 2;
  localparam int CARRIER_HZ  = OSC_HZ / (PRE_DIV * CAR_DIV);
  localparam int BAUD        = 9600;
  localparam int CARRIER_MIN = 48_000;

  // One delay tick is one period of the divided oscillator
  localparam int TICK_NS     = (1_000_000_000 / OSC_HZ) * PRE_DIV;

  // Delay times and their tick counts, least times rounded up
  localparam int REBIAS_NS   = 24_000;
  localparam int DEMOD_NS    = 16_000;
  localparam int STRETCH_NS  = 16_000;
  localparam int DLY_W       = 8;
  localparam logic [DLY_W-1:0] REBIAS_TICKS  =
    DLY_W'((REBIAS_NS + TICK_NS - 1) / TICK_NS);
  localparam logic [DLY_W-1:0] DEMOD_TICKS   =
    DLY_W'((DEMOD_NS + TICK_NS - 1) / TICK_NS);
  localparam logic [DLY_W-1:0] STRETCH_TICKS =
    DLY_W'((STRETCH_NS + TICK_NS - 1) / TICK_NS);

  // Register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_DLY_REBIAS  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_DLY_DEMOD   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DLY_STRETCH = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS      = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_PULSE_CNT   = 8'h10;

  // Status fields
  localparam int ST_TX_ACTIVE = 0;
  localparam int ST_RX_OPEN   = 1;
  localparam int ST_DEMOD_LOW = 2;
  localparam int ST_RX_LEVEL  = 3;
  localparam int ST_CAR_SEEN  = 8;

  localparam int CNT_W = 16;

endpackage : ook_modem_pkg

// *** rtl/clk_divider.sv ***
`timescale 1ns/1ns
`default_nettype none

module clk_divider #(
  parameter int DIV = 25
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Enable in, divided pulse out
  input  wire logic en,
  output logic      tick
);

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

  generate
    if (DIV < 1)
    begin : g_chk
      $error("clk_divider: DIV must be at least 1");
    end
  endgenerate

  logic [CW-1:0] cnt_r;
  wire           wrap = (cnt_r == CW'(DIV - 1));

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end
    else
    begin
      tick <= en & wrap;
      if (en)
        cnt_r <= wrap ? '0 : cnt_r + CW'(1);
    end
  end

endmodule : clk_divider

`default_nettype wire

// *** rtl/edge_delay.sv ***
`timescale 1ns/1ns
`default_nettype none

// Delays one edge of din by load+1 ticks; the other edge passes at once.
// FALL=0 delays rising edges, FALL=1 delays falling edges.
module edge_delay #(
  parameter int W    = 8,
  parameter bit FALL = 1'b0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Timing
  input  wire logic         tick,
  input  wire logic [W-1:0] load,
  // Signal
  input  wire logic         din,
  input  wire logic         retrig,
  output logic              dout
);

  generate
    if (W < 1)
    begin : g_chk
      $error("edge_delay: W must be at least 1");
    end
  endgenerate

  logic [W-1:0] cnt_r;
  logic         hit_r;
  wire          act = din ^ FALL;

  // Counting from load to zero takes load+1 ticks: never shorter than set
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= '0;
      hit_r <= 1'b0;
    end
    else if (!act || retrig)
    begin
      cnt_r <= load;
      hit_r <= 1'b0;
    end
    else if (!hit_r && tick)
    begin
      if (cnt_r == '0)
        hit_r <= 1'b1;
      else
        cnt_r <= cnt_r - W'(1);
    end
  end

  assign dout = hit_r ^ FALL;

endmodule : edge_delay

`default_nettype wire

// *** rtl/ook_powerline_modem.sv ***
// How it works
// - Transmit input low: drive carrier, pin output
// - Transmit input high: pin floats, no carrier
// - Carrier is 2 MHz divided by eight, four
// - 9600 baud link, carrier above 48 kHz
// - Oscillator chain always runs, no power-down
// - Wait 24 us after transmit before demodulating
// - Receive forced idle while blank delay input low
// - Pulse edges hold low; 16 us rise delay
// - 16 us fall delay restores low length
// - Transmit input idles high, single-sample, no filter
// - Receive output driven both ways from flop
// - Carrier present means low, absent means high
`timescale 1ns/1ns
`default_nettype none

module ook_powerline_modem (
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        RESET,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Local UART
  input  wire logic        UART_TX,
  output logic             UART_RX,
  // Power line pin
  input  wire logic        LINE_IO_I,
  output logic             LINE_IO_O,
  output logic             LINE_IO_OE
);

  localparam int DW = ook_modem_pkg::DLY_W;
  localparam int CW = ook_modem_pkg::CNT_W;

  generate
    if (ook_modem_pkg::CARRIER_HZ <= ook_modem_pkg::CARRIER_MIN ||
        ook_modem_pkg::CARRIER_MIN < 5 * ook_modem_pkg::BAUD)
    begin : g_chk
      $error("carrier too slow for the serial rate");
    end
  endgenerate

  // Oscillator chain, never gated
  logic osc_tick;
  logic pre_tick;
  logic half_tick;
  logic carrier_r;

  clk_divider #(.DIV(ook_modem_pkg::OSC_DIV)) u_osc (
    .clk  (MCLK),
    .rst  (RESET),
    .en   (1'b1),
    .tick (osc_tick)
  );

  clk_divider #(.DIV(ook_modem_pkg::PRE_DIV)) u_pre (
    .clk  (MCLK),
    .rst  (RESET),
    .en   (osc_tick),
    .tick (pre_tick)
  );

  clk_divider #(.DIV(ook_modem_pkg::CAR_HALF)) u_car (
    .clk  (MCLK),
    .rst  (RESET),
    .en   (pre_tick),
    .tick (half_tick)
  );

  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
      carrier_r <= 1'b0;
    else if (half_tick)
      carrier_r <= ~carrier_r;
  end

  // Transmit side. The pad pull-up keeps an open input high; here the
  // sample resets high too so a fresh part starts in receive mode.
  logic tx_r;
  logic line_q;

  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
      tx_r <= 1'b1;
    else
      tx_r <= UART_TX;
  end

  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      LINE_IO_OE <= 1'b0;
      LINE_IO_O  <= 1'b0;
    end
    else
    begin
      LINE_IO_OE <= ~tx_r;
      LINE_IO_O  <= ~tx_r & carrier_r;
    end
  end

  // Receive side
  logic [DW-1:0] dly_rebias_r;
  logic [DW-1:0] dly_demod_r;
  logic [DW-1:0] dly_stretch_r;
  logic          rx_open;
  logic          demod_idle;
  logic          stretch_out;

  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
      line_q <= 1'b0;
    else
      line_q <= LINE_IO_I;
  end

  // Own carrier is ignored: edges count only while the pin floats
  wire pulse_edge = (LINE_IO_I != line_q) & ~LINE_IO_OE;
  wire rx_edge    = pulse_edge & rx_open;

  edge_delay #(.W(DW), .FALL(1'b0)) u_rebias_blank_delay (
    .clk    (MCLK),
    .rst    (RESET),
    .tick   (pre_tick),
    .load   (dly_rebias_r),
    .din    (tx_r),
    .retrig (1'b0),
    .dout   (rx_open)
  );

  edge_delay #(.W(DW), .FALL(1'b0)) u_demod_rise_delay (
    .clk    (MCLK),
    .rst    (RESET),
    .tick   (pre_tick),
    .load   (dly_demod_r),
    .din    (1'b1),
    .retrig (rx_edge),
    .dout   (demod_idle)
  );

  edge_delay #(.W(DW), .FALL(1'b1)) u_stretch_fall_delay (
    .clk    (MCLK),
    .rst    (RESET),
    .tick   (pre_tick),
    .load   (dly_stretch_r),
    .din    (demod_idle),
    .retrig (1'b0),
    .dout   (stretch_out)
  );

  // Gate is high while the blank delay input is low or still timing
  wire rx_gate = ~tx_r | ~rx_open;
  wire rx_nxt  = rx_gate | stretch_out;

  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
      UART_RX <= 1'b1;
    else
      UART_RX <= rx_nxt;
  end

  // APB slave: one wait state, registered answer
  logic          car_seen_r;
  logic [CW-1:0] pulse_cnt_r;

  wire setup_acc = PSEL & PENABLE & ~PREADY;
  wire done_acc  = PSEL & PENABLE & PREADY;
  wire wr_acc    = done_acc & PWRITE;

  wire hit_rebias  = (PADDR == ook_modem_pkg::OFS_DLY_REBIAS);
  wire hit_demod   = (PADDR == ook_modem_pkg::OFS_DLY_DEMOD);
  wire hit_stretch = (PADDR == ook_modem_pkg::OFS_DLY_STRETCH);
  wire hit_status  = (PADDR == ook_modem_pkg::OFS_STATUS);
  wire hit_cnt     = (PADDR == ook_modem_pkg::OFS_PULSE_CNT);
  wire hit_any     = hit_rebias | hit_demod | hit_stretch |
                     hit_status | hit_cnt;

  logic [31:0] status_w;
  always_comb
  begin
    status_w = 32'h0000_0000;
    status_w[ook_modem_pkg::ST_TX_ACTIVE] = LINE_IO_OE;
    status_w[ook_modem_pkg::ST_RX_OPEN]   = rx_open;
    status_w[ook_modem_pkg::ST_DEMOD_LOW] = ~demod_idle;
    status_w[ook_modem_pkg::ST_RX_LEVEL]  = UART_RX;
    status_w[ook_modem_pkg::ST_CAR_SEEN]  = car_seen_r;
  end

  wire [31:0] rd_data =
    hit_rebias  ? {{(32-DW){1'b0}}, dly_rebias_r}  :
    hit_demod   ? {{(32-DW){1'b0}}, dly_demod_r}   :
    hit_stretch ? {{(32-DW){1'b0}}, dly_stretch_r} :
    hit_status  ? status_w                          :
    hit_cnt     ? {{(32-CW){1'b0}}, pulse_cnt_r}   :
                  32'h0000_0000;

  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end
    else
    begin
      PREADY  <= setup_acc;
      PSLVERR <= setup_acc & ~hit_any;
      if (setup_acc && !PWRITE)
        PRDATA <= rd_data;
    end
  end

  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      dly_rebias_r  <= ook_modem_pkg::REBIAS_TICKS;
      dly_demod_r   <= ook_modem_pkg::DEMOD_TICKS;
      dly_stretch_r <= ook_modem_pkg::STRETCH_TICKS;
    end
    else if (wr_acc)
    begin
      if (hit_rebias)
        dly_rebias_r <= PWDATA[DW-1:0];
      if (hit_demod)
        dly_demod_r <= PWDATA[DW-1:0];
      if (hit_stretch)
        dly_stretch_r <= PWDATA[DW-1:0];
    end
  end

  // Event beats clear in the same cycle
  wire seen_clr = wr_acc & hit_status & PWDATA[ook_modem_pkg::ST_CAR_SEEN];
  wire cnt_clr  = wr_acc & hit_cnt;

  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      car_seen_r  <= 1'b0;
      pulse_cnt_r <= '0;
    end
    else
    begin
      if (rx_edge)
        car_seen_r <= 1'b1;
      else if (seen_clr)
        car_seen_r <= 1'b0;
      if (rx_edge)
        pulse_cnt_r <= (cnt_clr ? '0 : pulse_cnt_r) + CW'(1);
      else if (cnt_clr)
        pulse_cnt_r <= '0;
    end
  end

endmodule : ook_powerline_modem

`default_nettype wire

// *** bench/ook_powerline_modem_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none

module modem_monitor (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RESET,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Serial and line
  input wire logic UART_TX,
  input wire logic UART_RX,
  input wire logic LINE_IO_I,
  input wire logic LINE_IO_O,
  input wire logic LINE_IO_OE
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RESET);
  logic [11:0] run_r;
  logic [11:0] open_r;
  logic [11:0] idle_r;
  // Cycles since the first line edge of a burst while UART_RX stays high
  logic [11:0] fall_r;
  logic        o_q_r;
  logic        i_q_r;
  // open_r and idle_r saturate so long idle spans never wrap
  always_ff @(posedge MCLK or posedge RESET)
    if (RESET)
    begin
      run_r  <= '0;
      open_r <= '0;
      idle_r <= '0;
      fall_r <= '0;
      o_q_r  <= 1'b0;
      i_q_r  <= 1'b0;
    end
    else
    begin
      o_q_r  <= LINE_IO_O;
      i_q_r  <= LINE_IO_I;
      run_r  <= (!LINE_IO_OE || LINE_IO_O != o_q_r) ? '0 : run_r + 1'b1;
      open_r <= LINE_IO_OE ? '0 : open_r + 12'(open_r != 12'hfff);
      idle_r <= (LINE_IO_I != i_q_r) ? '0 : idle_r + 12'(idle_r != 12'hfff);
      if (!UART_RX || open_r != 12'hfff)
        fall_r <= '0;
      else if (fall_r != 12'd0 || LINE_IO_I != i_q_r)
        fall_r <= fall_r + 12'd1;
    end
  property p_oe_on;   !UART_TX [*3] |-> LINE_IO_OE; endproperty
  property p_oe_off;  UART_TX [*3] |-> !LINE_IO_OE && !LINE_IO_O; endproperty
  property p_gate;    !LINE_IO_OE |-> !LINE_IO_O; endproperty
  property p_half;    run_r < 12'd400; endproperty
  property p_tx_idle; LINE_IO_OE |-> UART_RX; endproperty
  property p_blank;   open_r < 12'd1200 |-> UART_RX; endproperty
  property p_fall;    fall_r < 12'd1010; endproperty
  property p_rise;    idle_r == 12'd1010 && open_r == 12'hfff |-> UART_RX;
  endproperty
  property p_ready;   PSEL && $rose(PENABLE) |-> !PREADY ##1 PREADY;
  endproperty
  property p_err;     PSLVERR |-> PREADY; endproperty
  a_oe_on:   assert property (p_oe_on) else $error("line not driven");
  a_oe_off:  assert property (p_oe_off) else $error("line driven");
  a_gate:    assert property (p_gate) else $error("carrier ungated");
  a_half:    assert property (p_half) else $error("carrier slow");
  a_tx_idle: assert property (p_tx_idle) else $error("rx not idle");
  a_blank:   assert property (p_blank) else $error("blank short");
  a_fall:    assert property (p_fall) else $error("rx no fall");
  a_rise:    assert property (p_rise) else $error("rx no rise");
  a_ready:   assert property (p_ready) else $error("ready timing");
  a_err:     assert property (p_err) else $error("error no ready");
  c_tx:  cover property (LINE_IO_OE ##1 !LINE_IO_OE);
  c_rx:  cover property ($fell(UART_RX));
  c_err: cover property (PSLVERR);
endmodule : modem_monitor

bind ook_powerline_modem modem_monitor i_mon (.MCLK(MCLK), .RESET(RESET),
  .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .UART_TX(UART_TX), .UART_RX(UART_RX), .LINE_IO_I(LINE_IO_I),
  .LINE_IO_O(LINE_IO_O), .LINE_IO_OE(LINE_IO_OE));

`default_nettype wire

// *** bench/peer_line_model.sv ***
`timescale 1ns/1ns
`default_nettype none

module peer_line_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Peer serial level, low sends carrier
  input  wire logic tx_n,
  // Local pin
  input  wire logic o,
  input  wire logic oe,
  output logic      line
);
  logic [8:0] half_r;
  logic       lvl_r;
  // One edge each 400 clocks: 62.5 kHz, above the 9600 baud minimum
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      half_r <= '0;
      lvl_r  <= 1'b1;
    end
    else if (tx_n)
      half_r <= '0;
    else
    begin
      half_r <= (half_r == 9'd399) ? '0 : half_r + 1'b1;
      lvl_r  <= (half_r == 9'd0) ? !lvl_r : lvl_r;
    end
  // The pin reads back its own carrier while it drives
  assign line = oe ? o : lvl_r;
endmodule : peer_line_model

`default_nettype wire

// *** bench/test_ook_powerline_modem.sv ***
`timescale 1ns/1ns
`default_nettype none

module test_ook_powerline_modem;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        utx = 1'b1;
  logic        ptx_n = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        urx;
  logic        line_i;
  logic        line_o;
  logic        line_oe;
  logic        lo;
  int          bad_count = 0;
  int          check_count = 0;
  int          n;
  int          tf;
  int          tr;

  always #10 mclk = ~mclk;

  ook_powerline_modem i_dut (.MCLK(mclk), .RESET(reset), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .UART_TX(utx),
    .UART_RX(urx), .LINE_IO_I(line_i), .LINE_IO_O(line_o),
    .LINE_IO_OE(line_oe));
  peer_line_model i_peer (.clk(mclk), .rst(reset), .tx_n(ptx_n),
    .o(line_o), .oe(line_oe), .line(line_i));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] e,
                     input logic er);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1 && ++k < 20);
    if (!w)
      chk(prdata, e);
    chk({30'h0, pready, pslverr}, {30'h0, 1'b1, er});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  initial
  begin
    #(40_000 * 20);
    bad_count++;
    stop_test();
  end

  initial
  begin
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    apb(1'b0, 8'h00, 32'h0, 32'h6, 1'b0);
    apb(1'b0, 8'h04, 32'h0, 32'h4, 1'b0);
    apb(1'b1, 8'h08, 32'h4, 32'h0, 1'b0);
    apb(1'b0, 8'h08, 32'h0, 32'h4, 1'b0);
    apb(1'b1, 8'h20, 32'h5, 32'h0, 1'b1);
    apb(1'b0, 8'h20, 32'h0, 32'h0, 1'b1);
    utx <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(32'(line_oe), 32'h1);
    n = 0;
    lo = line_o;
    repeat (1600)
    begin
      @(posedge mclk);
      n += int'(line_o !== lo);
      lo = line_o;
    end
    chk(n, 32'h4);
    chk(32'(urx), 32'h1);
    utx <= 1'b1;
    ptx_n <= 1'b0;
    repeat (3) @(posedge mclk);
    chk({line_oe, line_o}, 32'h0);
    // Peer talks at once: its pulses must be ignored while the line settles
    n = 0;
    repeat (1150)
    begin
      @(posedge mclk);
      n += int'(urx !== 1'b1);
    end
    chk(n, 32'h0);
    ptx_n <= 1'b1;
    repeat (4200) @(posedge mclk);
    apb(1'b1, 8'h10, 32'h0, 32'h0, 1'b0);
    apb(1'b1, 8'h0c, 32'h100, 32'h0, 1'b0);
    ptx_n <= 1'b0;
    tf = -1;
    tr = -1;
    for (n = 0; n < 7000; n++)
    begin
      @(posedge mclk);
      if (n == 5000)
        ptx_n <= 1'b1;
      if (urx !== 1'b1 && tf < 0)
        tf = n;
      if (urx === 1'b1 && tf >= 0 && tr < 0)
        tr = n;
    end
    chk(32'(tf >= 795 && tf <= 1010), 32'h1);
    chk(32'(tr - tf >= 4580 && tr - tf <= 5020), 32'h1);
    apb(1'b0, 8'h10, 32'h0, 32'd13, 1'b0);
    apb(1'b0, 8'h0c, 32'h0, 32'h10a, 1'b0);
    apb(1'b1, 8'h0c, 32'h100, 32'h0, 1'b0);
    apb(1'b0, 8'h0c, 32'h0, 32'h00a, 1'b0);
    stop_test();
  end
endmodule : test_ook_powerline_modem

`default_nettype wire
